// file: src/phy_status_cfg.svh
// offsets, bit positions, widths and reset values of the status registers
`ifndef PHY_STATUS_CFG_SVH
`define PHY_STATUS_CFG_SVH

`define REG_ADDR_W          5
`define REG_DATA_W          16

`define BASE_STATUS_OFF     5'h01
`define AN_EXPANSION_OFF    5'h06
`define LIVE_STATUS_OFF     5'h11
`define CHANGE_FLAGS_OFF    5'h13

`define SPEED_BIT           14
`define TX_ACT_BIT          13
`define RX_ACT_BIT          12
`define COLLISION_BIT       11
`define LINK_BIT            10
`define DUPLEX_BIT          9
`define AN_MODE_BIT         8
`define AN_DONE_BIT         7
`define POLARITY_BIT        5
`define PAUSE_BIT           4
`define ERROR_BIT           3

`define NEG_DONE_FLAG_BIT   7
`define SPEED_CHG_FLAG_BIT  6
`define DUPLEX_CHG_FLAG_BIT 5
`define LINK_CHG_FLAG_BIT   4

`define FLAG_COUNT          4
`define FLAG_LINK_IDX       0
`define FLAG_DUPLEX_IDX     1
`define FLAG_SPEED_IDX      2
`define FLAG_NEG_DONE_IDX   3

`define REG_RESET_VALUE     16'h0000
`define FLAGS_RESET_VALUE   4'h0

`endif

// file: src/phy_status_pkg.sv
// state types shared by the status register bank and its change latch
package phy_status_pkg;

  typedef struct packed {
    logic        prev_speed;
    logic        prev_duplex;
    logic        prev_link;
    logic        prev_neg_done;
    logic        primed;
    logic        err_remote_fault;
    logic        err_jabber;
    logic        err_par_detect;
    logic [15:0] rd_data;
    logic        rd_valid;
  } bank_state_t;

  typedef struct packed {
    logic [3:0] flags;
  } latch_state_t;

endpackage

// file: src/change_if.sv
// carrier between the register bank and its sticky change latch
`timescale 1ns/10ps
interface change_if #(
  parameter int WIDTH = 4
);
  logic [WIDTH-1:0] events;
  logic             clear;
  logic [WIDTH-1:0] flags;

  modport owner (
    output events,
    output clear,
    input  flags
  );

  modport latch (
    input  events,
    input  clear,
    output flags
  );
endinterface

// file: src/change_latch.sv
// sticky change flags: set on event, cleared by a read, set beats clear
`timescale 1ns/10ps
`include "phy_status_cfg.svh"
module change_latch
  import phy_status_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  change_if.latch   chg
);

  latch_state_t st_r;
  latch_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // an event in the clearing cycle survives for the next read
    st_nxt.flags = (st_r.flags & ~{WIDTH{chg.clear}}) | chg.events; // R14
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.flags <= `FLAGS_RESET_VALUE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chg.flags = st_r.flags;

endmodule

// file: src/phy_status_change_registers.sv
// live status register and sticky change-flag register of the transceiver
//
// What this block does
// R01: the speed bit reads one while the port runs 100 Mb/s twisted pair and zero otherwise.
// R02: the transmit-activity bit reads one while a packet is being sent.
// R03: the receive-activity bit reads one while a packet is arriving.
// R04: collision, link-up and full-duplex each show as a live bit.
// R05: the negotiation-mode bit reads one when automatic negotiation is enabled.
// R06: the negotiation-complete bit mirrors base status bit 1.5.
// R07: the polarity bit reads one on reversed receive polarity, and means nothing at 100 Mb/s.
// R08: the pause bit reports pause-frame capability.
// R09: remote fault, jabber or parallel-detect fault sets the error bit until its source is read.
// R10: the negotiation-done flag latches on completion; a change-register read clears it.
// R11: the speed-change flag latches on any speed change; a change-register read clears it.
// R12: the duplex-change flag latches on any duplex change; a change-register read clears it.
// R13: the link-change flag latches on any link toggle and clears on reading the change register.
// R14: the clearing read returns the flags, and a change in that same cycle stays latched.
`timescale 1ns/10ps
`include "phy_status_cfg.svh"
module phy_status_change_registers
  import phy_status_pkg::*;
#(
  parameter int ADDR_W = `REG_ADDR_W,
  parameter int DATA_W = `REG_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // live conditions from the transceiver core
  input  wire logic              speed_100,
  input  wire logic              tx_active,
  input  wire logic              rx_active,
  input  wire logic              collision,
  input  wire logic              link_up,
  input  wire logic              full_duplex,
  input  wire logic              autoneg_en,
  input  wire logic              autoneg_done,
  input  wire logic              polarity_reversed,
  input  wire logic              pause_capable,
  input  wire logic              remote_fault,
  input  wire logic              jabber,
  input  wire logic              par_detect_fault,
  // register read port from the serial management engine
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output      logic [DATA_W-1:0] rd_data,
  output      logic              rd_valid
);

  bank_state_t st_r;
  bank_state_t st_nxt;

  change_if #(.WIDTH(`FLAG_COUNT)) chg ();

  change_latch #(
    .WIDTH (`FLAG_COUNT)
  ) u_change_latch (
    .clk   (clk),
    .rst   (rst),
    .chg   (chg.latch)
  );

  // read decode
  logic rd_live;
  logic rd_change;
  logic rd_base;
  logic rd_expansion;

  assign rd_live      = rd_en && (rd_addr == `LIVE_STATUS_OFF);
  assign rd_change    = rd_en && (rd_addr == `CHANGE_FLAGS_OFF);
  assign rd_base      = rd_en && (rd_addr == `BASE_STATUS_OFF);
  assign rd_expansion = rd_en && (rd_addr == `AN_EXPANSION_OFF);

  // change detection, held off until the first sample after reset so that
  // conditions already present at reset are not reported as changes
  logic [`FLAG_COUNT-1:0] events;

  always_comb begin
    events = '0;
    if (st_r.primed) begin
      events[`FLAG_SPEED_IDX]    = speed_100 ^ st_r.prev_speed;       // R11
      events[`FLAG_DUPLEX_IDX]   = full_duplex ^ st_r.prev_duplex;    // R12
      events[`FLAG_LINK_IDX]     = link_up ^ st_r.prev_link;          // R13
      events[`FLAG_NEG_DONE_IDX] = autoneg_done & ~st_r.prev_neg_done; // R10
    end
  end

  assign chg.events = events;
  assign chg.clear  = rd_change; // R10 R11 R12 R13

  // live status word
  logic [DATA_W-1:0] live_word;

  always_comb begin
    live_word                 = `REG_RESET_VALUE;
    live_word[`SPEED_BIT]     = speed_100;          // R01
    live_word[`TX_ACT_BIT]    = tx_active;          // R02
    live_word[`RX_ACT_BIT]    = rx_active;          // R03
    live_word[`COLLISION_BIT] = collision;          // R04
    live_word[`LINK_BIT]      = link_up;            // R04
    live_word[`DUPLEX_BIT]    = full_duplex;        // R04
    live_word[`AN_MODE_BIT]   = autoneg_en;         // R05
    // same source as base status bit 1.5; only meaningful with negotiation on
    live_word[`AN_DONE_BIT]   = autoneg_done;       // R06
    // software ignores this at 100 Mb/s, so it is passed through unqualified
    live_word[`POLARITY_BIT]  = polarity_reversed;  // R07
    live_word[`PAUSE_BIT]     = pause_capable;      // R08
    live_word[`ERROR_BIT]     = st_r.err_remote_fault
                              | st_r.err_jabber
                              | st_r.err_par_detect; // R09
  end

  // change-flag word, read from the latch before this cycle's clear
  logic [DATA_W-1:0] change_word;

  always_comb begin
    change_word                       = `REG_RESET_VALUE;
    change_word[`NEG_DONE_FLAG_BIT]   = chg.flags[`FLAG_NEG_DONE_IDX]; // R10 R14
    change_word[`SPEED_CHG_FLAG_BIT]  = chg.flags[`FLAG_SPEED_IDX];    // R11 R14
    change_word[`DUPLEX_CHG_FLAG_BIT] = chg.flags[`FLAG_DUPLEX_IDX];   // R12 R14
    change_word[`LINK_CHG_FLAG_BIT]   = chg.flags[`FLAG_LINK_IDX];     // R13 R14
  end

  always_comb begin
    st_nxt = st_r;

    st_nxt.primed        = 1'b1;
    st_nxt.prev_speed    = speed_100;
    st_nxt.prev_duplex   = full_duplex;
    st_nxt.prev_link     = link_up;
    st_nxt.prev_neg_done = autoneg_done;

    // error sources: remote fault and jabber live in the base status
    // register, parallel-detect fault in the expansion register; a fault
    // present during the clearing read keeps its bit set
    st_nxt.err_remote_fault = (st_r.err_remote_fault & ~rd_base) | remote_fault;      // R09
    st_nxt.err_jabber       = (st_r.err_jabber & ~rd_base) | jabber;                  // R09
    st_nxt.err_par_detect   = (st_r.err_par_detect & ~rd_expansion) | par_detect_fault; // R09

    // answer one cycle after the request; other addresses belong to other
    // register banks, so this bank answers only its own two
    st_nxt.rd_valid = rd_live | rd_change;
    if (rd_live) begin
      st_nxt.rd_data = live_word;
    end else if (rd_change) begin
      st_nxt.rd_data = change_word; // R14
    end else begin
      st_nxt.rd_data = st_r.rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.prev_speed       <= 1'b0;
      st_r.prev_duplex      <= 1'b0;
      st_r.prev_link        <= 1'b0;
      st_r.prev_neg_done    <= 1'b0;
      st_r.primed           <= 1'b0;
      st_r.err_remote_fault <= 1'b0;
      st_r.err_jabber       <= 1'b0;
      st_r.err_par_detect   <= 1'b0;
      st_r.rd_data          <= `REG_RESET_VALUE;
      st_r.rd_valid         <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data  = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;

endmodule

// file: testbench/status_checker_assertions.sv
// read-port checks for the live status and sticky change-flag registers
`timescale 1ns/10ps
module status_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        speed_100,
  input wire logic        tx_active,
  input wire logic        rx_active,
  input wire logic        collision,
  input wire logic        link_up,
  input wire logic        full_duplex,
  input wire logic        autoneg_en,
  input wire logic        autoneg_done,
  input wire logic        polarity_reversed,
  input wire logic        pause_capable,
  input wire logic        remote_fault,
  input wire logic        rd_en,
  input wire logic [4:0]  rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid
);
  // first cycles after reset only prime the change detectors
  logic [1:0] age_r;
  always_ff @(posedge clk) begin
    if (rst) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence live_rd; rd_en && rd_addr == 5'h11; endsequence
  sequence flag_rd; rd_en && rd_addr == 5'h13; endsequence
  sequence quiet;
    age_r == 2'h3 && $stable(link_up) && $stable(full_duplex) && $stable(speed_100)
      && !$rose(autoneg_done);
  endsequence
  read_answer_a:
    assert property (live_rd or flag_rd |=> rd_valid) else $error("read not answered");
  live_word_a:
    assert property (live_rd |=> (rd_data & 16'hfff7) == $past({1'b0, speed_100, tx_active,
      rx_active, collision, link_up, full_duplex, autoneg_en, autoneg_done, 1'b0,
      polarity_reversed, pause_capable, 4'h0})) else $error("live word wrong");
  error_set_a:
    assert property (age_r == 2'h3 && $fell(remote_fault) && !rd_en ##1 live_rd |=> rd_data[3])
      else $error("error bit not latched");
  link_flag_a:
    assert property (age_r == 2'h3 && $changed(link_up) ##1 flag_rd |=> rd_data[4])
      else $error("link flag missing");
  duplex_flag_a:
    assert property (age_r == 2'h3 && $changed(full_duplex) ##1 flag_rd |=> rd_data[5])
      else $error("duplex flag missing");
  speed_flag_a:
    assert property (age_r == 2'h3 && $changed(speed_100) ##1 flag_rd |=> rd_data[6])
      else $error("speed flag missing");
  done_flag_a:
    assert property (age_r == 2'h3 && $rose(autoneg_done) ##1 flag_rd |=> rd_data[7])
      else $error("done flag missing");
  flag_clear_a:
    assert property (flag_rd ##0 quiet ##1 quiet ##1 flag_rd |=> rd_data[7:4] == 4'h0)
      else $error("flags not cleared");
  valid_pulse_a:
    assert property (!(rd_en && (rd_addr == 5'h11 || rd_addr == 5'h13)) |=> !rd_valid)
      else $error("answer without a read");
  data_hold_a:
    assert property (!rd_valid |-> $stable(rd_data)) else $error("read data not held");
endmodule
bind phy_status_change_registers status_checker u_chk (
  .clk               (clk),
  .rst               (rst),
  .speed_100         (speed_100),
  .tx_active         (tx_active),
  .rx_active         (rx_active),
  .collision         (collision),
  .link_up           (link_up),
  .full_duplex       (full_duplex),
  .autoneg_en        (autoneg_en),
  .autoneg_done      (autoneg_done),
  .polarity_reversed (polarity_reversed),
  .pause_capable     (pause_capable),
  .remote_fault      (remote_fault),
  .rd_en             (rd_en),
  .rd_addr           (rd_addr),
  .rd_data           (rd_data),
  .rd_valid          (rd_valid)
);

// file: testbench/testbench.sv
// self-checking bench for the status and change-flag registers
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        rst;
  logic        rd_en;
  logic        rd_valid;
  logic [4:0]  rd_addr;
  logic [2:0]  ef;
  logic [15:0] st;
  logic [15:0] rd_data;
  int          n_fail;
  int          num_checks;
  // st mirrors the live word layout so expectations are plain masks
  phy_status_change_registers i_dut (
    .clk(clk), .rst(rst), .speed_100(st[14]), .tx_active(st[13]), .rx_active(st[12]),
    .collision(st[11]), .link_up(st[10]), .full_duplex(st[9]), .autoneg_en(st[8]),
    .autoneg_done(st[7]), .polarity_reversed(st[5]), .pause_capable(st[4]),
    .remote_fault(ef[0]), .jabber(ef[1]), .par_detect_fault(ef[2]), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic v);
    @(posedge clk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp({15'h0000, rd_valid}, {15'h0000, v});
    // refused addresses must leave the last answer in place
    cmp(rd_data, exp);
  endtask
  // wrong clearing address first: the latch must survive it
  task automatic t_error();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      ef <= 3'h1 << i;
      @(posedge clk);
      ef <= 3'h0;
      rd(5'h11, 16'h0008, 1'b1);
      rd((i == 2) ? 5'h01 : 5'h06, 16'h0008, 1'b0);
      rd(5'h11, 16'h0008, 1'b1);
      rd((i == 2) ? 5'h06 : 5'h01, 16'h0008, 1'b0);
      rd(5'h11, 16'h0000, 1'b1);
    end
  endtask
  task automatic t_live();
    int b[10] = '{14, 13, 12, 11, 10, 9, 8, 7, 5, 4};
    foreach (b[k]) begin
      @(posedge clk);
      st <= 16'h0001 << b[k];
      rd(5'h11, 16'h0001 << b[k], 1'b1);
    end
  endtask
  task automatic t_flags();
    int b[4] = '{10, 9, 14, 7};
    rd(5'h13, 16'h00f0, 1'b1);
    rd(5'h13, 16'h0000, 1'b1);
    foreach (b[k]) begin
      @(posedge clk);
      st <= st ^ (16'h0001 << b[k]);
      rd(5'h13, 16'h0010 << k, 1'b1);
      rd(5'h13, 16'h0000, 1'b1);
    end
  endtask
  // link toggles in the very cycle of the clearing read
  task automatic t_same();
    @(posedge clk);
    rd_en   <= 1'b1;
    rd_addr <= 5'h13;
    st[10]  <= ~st[10];
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp(rd_data, 16'h0000);
    rd(5'h13, 16'h0010, 1'b1);
  endtask
  // mid-run reset drops a pending link flag and a latched jabber error
  task automatic t_reset();
    @(posedge clk);
    st[10] <= ~st[10];
    ef     <= 3'h2;
    @(posedge clk);
    ef  <= 3'h0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(5'h13, 16'h0000, 1'b1);
    rd(5'h11, st, 1'b1);
  endtask
  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst     = 1'b1;
    rd_en   = 1'b0;
    rd_addr = 5'h00;
    st      = 16'h0000;
    ef      = 3'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(5'h11, 16'h0000, 1'b1);
    rd(5'h13, 16'h0000, 1'b1);
    rd(5'h05, 16'h0000, 1'b0);
    t_error();
    t_live();
    t_flags();
    t_same();
    t_reset();
    end_sim();
  end
endmodule
